// [rtl/gfs_cfg_block.sv]
// Status, revision and class code slice of the second graphics function.
`timescale 1ns/1ps
`include "gfs_params.svh"

// Summary of operation
// RULE1: Read-only status register, resets to 0090h.
// RULE2: Parity fault and system error bits read zero.
// RULE3: All three abort status bits read zero.
// RULE4: Select timing field bits 10:9 read 00.
// RULE5: Initiator data parity flag reads zero.
// RULE6: Back-to-back capable bit 7 reads one.
// RULE7: User format, fast bus, interrupt bits read zero.
// RULE8: Capabilities present bit 4 reads one.
// RULE9: Revision shares function zero's storage.
// RULE10: Class code reads 038000h, display non-VGA.
// RULE11: Writes ignored; reserved status bits read zero.
module gfs_cfg_block
	import gfs_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_srst,
	input  wire logic        i_cfg_rd,
	input  wire logic        i_cfg_wr,
	input  wire logic [7:0]  i_cfg_addr,
	input  wire logic [3:0]  i_cfg_be,
	input  wire logic [31:0] i_cfg_wdata,
	input  wire logic [7:0]  i_fn0_revision,
	output logic             o_cfg_ack,
	output logic             o_cfg_hit,
	output logic [31:0]      o_cfg_rdata
);

	gfs_status_t status_q;
	gfs_status_t status_d;
	gfs_class_t  class_q;
	gfs_class_t  class_d;
	gfs_dword_t  rdata_q;
	gfs_dword_t  rdata_d;
	logic        ack_q;
	logic        ack_d;
	logic        hit_q;
	logic        hit_d;
	gfs_region_t region;
	gfs_dword_t  mux_dword;
	logic [5:0]  dw_index;

	assign dw_index = i_cfg_addr[7:2];

	// Decode which of this block's dwords an access selects.
	always_comb begin
		if (dw_index == `GFS_DW_STATUS) begin
			region = GFS_REG_STATUS;
		end else if (dw_index == `GFS_DW_REVCLS) begin
			region = GFS_REG_REVCLS;
		end else begin
			region = GFS_REG_NONE;
		end
	end

	gfs_dword_mux u_mux (
		.i_region   (region),
		.i_status   (status_q),
		.i_revision (i_fn0_revision), // RULE9
		.i_class    (class_q),
		.o_dword    (mux_dword)
	);

	// Status and class contents are rebuilt from their fixed fields.
	always_comb begin
		status_d = '0;
		status_d[`GFS_BIT_PARITY_FAULT] = 1'b0; // RULE2
		status_d[`GFS_BIT_SYSERR]       = 1'b0; // RULE2
		status_d[`GFS_BIT_INIT_ABORT]   = 1'b0; // RULE3
		status_d[`GFS_BIT_COMP_ABORT]   = 1'b0; // RULE3
		status_d[`GFS_BIT_SENT_ABORT]   = 1'b0; // RULE3
		status_d[`GFS_BIT_TIMING_HI -: 2] = `GFS_SELECT_TIMING; // RULE4
		status_d[`GFS_BIT_INIT_PARITY]  = 1'b0; // RULE5
		status_d[`GFS_BIT_BACK_TO_BACK] = 1'b1; // RULE6
		status_d[`GFS_BIT_USER_FORMAT]  = 1'b0; // RULE7
		status_d[`GFS_BIT_FAST_BUS]     = 1'b0; // RULE7
		status_d[`GFS_BIT_CAPS_PRESENT] = 1'b1; // RULE8
		status_d[`GFS_BIT_INTR_STATUS]  = 1'b0; // RULE7
		status_d[`GFS_BIT_RSVD_HI -: 3] = 3'h0; // RULE11
		class_d = {`GFS_BASE_CLASS, `GFS_SUB_CLASS, `GFS_PROG_IFACE}; // RULE10
	end

	// Every access is answered one cycle later; writes change nothing.
	always_comb begin
		ack_d   = i_cfg_rd | i_cfg_wr; // RULE11
		hit_d   = (i_cfg_rd | i_cfg_wr) & (region != GFS_REG_NONE);
		rdata_d = '0;
		if (i_cfg_rd) begin
			rdata_d = mux_dword;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			status_q <= `GFS_STATUS_RESET; // RULE1
			class_q  <= `GFS_CLASS_RESET; // RULE10
			rdata_q  <= '0;
			ack_q    <= 1'b0;
			hit_q    <= 1'b0;
		end else begin
			status_q <= status_d; // RULE1
			class_q  <= class_d;
			rdata_q  <= rdata_d;
			ack_q    <= ack_d;
			hit_q    <= hit_d;
		end
	end

	assign o_cfg_ack   = ack_q;
	assign o_cfg_hit   = hit_q;
	assign o_cfg_rdata = rdata_q;

	// Checks.
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_srst);

	logic rd_sts;
	logic rd_rc;
	logic wr_any;
	assign rd_sts = i_cfg_rd & (dw_index == `GFS_DW_STATUS);
	assign rd_rc  = i_cfg_rd & (dw_index == `GFS_DW_REVCLS);
	assign wr_any = i_cfg_wr & ~i_cfg_rd & (|i_cfg_be)
		& (|i_cfg_wdata | ~|i_cfg_wdata);

	sequence s_answer;
		o_cfg_ack && o_cfg_hit;
	endsequence

	chk_status_value: assert property ( // RULE1
		rd_sts |=> s_answer
			and o_cfg_rdata[31:16] == `GFS_STATUS_RESET
	) else $error("Status read does not return its reset value.");

	chk_error_bits_zero: assert property ( // RULE2
		rd_sts |=> !o_cfg_rdata[`GFS_STATUS_LSB + `GFS_BIT_PARITY_FAULT]
			&& !o_cfg_rdata[`GFS_STATUS_LSB + `GFS_BIT_SYSERR]
	) else $error("Parity fault or system error bit reads one.");

	chk_abort_bits_zero: assert property ( // RULE3
		rd_sts |=> o_cfg_rdata[29:27] == 3'h0
	) else $error("An abort status bit reads one.");

	chk_select_timing: assert property ( // RULE4
		rd_sts |=> o_cfg_rdata[26:25] == `GFS_SELECT_TIMING
	) else $error("Select timing field is not zero.");

	chk_init_parity: assert property ( // RULE5
		rd_sts |=> !o_cfg_rdata[`GFS_STATUS_LSB + `GFS_BIT_INIT_PARITY]
	) else $error("Initiator data parity flag reads one.");

	chk_back_to_back: assert property ( // RULE6
		rd_sts |=> o_cfg_rdata[`GFS_STATUS_LSB + `GFS_BIT_BACK_TO_BACK]
	) else $error("Back-to-back capable bit reads zero.");

	chk_misc_zero: assert property ( // RULE7
		rd_sts |=> o_cfg_rdata[22] == 1'b0
			&& o_cfg_rdata[21] == 1'b0
			&& o_cfg_rdata[19] == 1'b0
	) else $error("Format, fast bus or interrupt bit reads one.");

	chk_caps_present: assert property ( // RULE8
		rd_sts |=> o_cfg_rdata[`GFS_STATUS_LSB + `GFS_BIT_CAPS_PRESENT]
	) else $error("Capabilities present bit reads zero.");

	chk_revision_shared: assert property ( // RULE9
		rd_rc |=> s_answer
			and o_cfg_rdata[7:0] == $past(i_fn0_revision)
	) else $error("Revision does not follow function zero storage.");

	chk_class_code: assert property ( // RULE10
		rd_rc |=> o_cfg_rdata[31:8] == `GFS_CLASS_RESET
	) else $error("Class code does not read 038000h.");

	chk_write_ignored: assert property ( // RULE11
		wr_any ##1 rd_sts |=> o_cfg_rdata[31:16] == `GFS_STATUS_RESET
	) else $error("A write altered the status register.");

	chk_reserved_zero: assert property ( // RULE11
		rd_sts |=> o_cfg_rdata[18:0] == 19'h0
	) else $error("Reserved or low status lanes read nonzero.");

	chk_ack_timing: assert property (
		(i_cfg_rd || i_cfg_wr) |=> o_cfg_ack
			##1 (o_cfg_ack == $past(i_cfg_rd || i_cfg_wr))
	) else $error("Answer is not given exactly one cycle later.");

	chk_write_no_data: assert property (
		(i_cfg_wr && !i_cfg_rd) |=> o_cfg_rdata == 32'h0
	) else $error("A write answer carries read data.");

	chk_unmapped_miss: assert property (
		(i_cfg_rd && dw_index != `GFS_DW_STATUS
			&& dw_index != `GFS_DW_REVCLS)
		|=> !o_cfg_hit && o_cfg_rdata == 32'h0
	) else $error("Unmapped read is claimed or returns data.");

	chk_idle_quiet: assert property (
		!(i_cfg_rd || i_cfg_wr) |=> !o_cfg_ack && !o_cfg_hit
	) else $error("Answer appears without a request.");

	// Fixed images rebuilt from the field positions, not the reset value.
	localparam logic [15:0] STATUS_ONES =
		(16'h0001 << `GFS_BIT_BACK_TO_BACK)
		| (16'h0001 << `GFS_BIT_CAPS_PRESENT);
	localparam logic [23:0] CLASS_IMAGE =
		{`GFS_BASE_CLASS, `GFS_SUB_CLASS, `GFS_PROG_IFACE};

	chk_status_reg_held: assert property ( // RULE1
		status_q == `GFS_STATUS_RESET
	) else $error("Status register left its fixed value.");

	chk_class_reg_held: assert property ( // RULE10
		class_q == CLASS_IMAGE && class_q == `GFS_CLASS_RESET
	) else $error("Class register left its fixed value.");

	chk_status_hit: assert property ( // RULE1
		rd_sts |=> o_cfg_ack && o_cfg_hit
	) else $error("Status read is not claimed.");

	chk_revcls_hit: assert property ( // RULE9
		rd_rc |=> o_cfg_ack && o_cfg_hit
	) else $error("Revision and class read is not claimed.");

	chk_class_fields: assert property ( // RULE10
		rd_rc |=> o_cfg_rdata[31:24] == `GFS_BASE_CLASS
			&& o_cfg_rdata[23:16] == `GFS_SUB_CLASS
			&& o_cfg_rdata[15:8] == `GFS_PROG_IFACE
	) else $error("A class code field reads wrong.");

	chk_write_claimed: assert property ( // RULE11
		(i_cfg_wr && !i_cfg_rd && region != GFS_REG_NONE)
		|=> o_cfg_ack && o_cfg_hit && o_cfg_rdata == 32'h0
	) else $error("Mapped write is not acknowledged cleanly.");

	chk_write_unmapped: assert property (
		(i_cfg_wr && !i_cfg_rd && region == GFS_REG_NONE)
		|=> o_cfg_ack && !o_cfg_hit && o_cfg_rdata == 32'h0
	) else $error("Unmapped write is claimed or returns data.");

	chk_read_wins: assert property ( // RULE11
		(i_cfg_rd && i_cfg_wr && dw_index == `GFS_DW_STATUS)
		|=> o_cfg_rdata[31:16] == `GFS_STATUS_RESET
	) else $error("Read with write does not return status.");

	chk_hit_with_ack: assert property (
		o_cfg_hit |-> o_cfg_ack
	) else $error("Hit shown without an answer.");

	chk_data_with_hit: assert property (
		o_cfg_rdata != 32'h0 |-> o_cfg_ack && o_cfg_hit
	) else $error("Read data shown without a claimed answer.");

	chk_status_steady: assert property ( // RULE1
		rd_sts ##1 rd_sts |=> $stable(o_cfg_rdata[31:16])
	) else $error("Status changes between two reads.");

	chk_reset_quiet: assert property ( // RULE1
		@(posedge i_mclk) disable iff (1'b0)
		i_srst |=> !o_cfg_ack && !o_cfg_hit && o_cfg_rdata == 32'h0
	) else $error("Answer lines are not cleared by reset.");

	// One check per status bit against the field positions.
	for (genvar b = 0; b < 16; b++) begin : g_status_bit
		chk_status_bit: assert property ( // RULE1
			@(posedge i_mclk) disable iff (i_srst)
			rd_sts |=> o_cfg_rdata[`GFS_STATUS_LSB + b]
				== STATUS_ONES[b]
		) else $error("A status bit differs from its fixed value.");
	end

	// Remembers that a write was seen, so later reads can be checked.
	logic wrote_q;
	logic wrote_d;

	always_comb begin
		wrote_d = wrote_q | wr_any;
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			wrote_q <= 1'b0;
		end else begin
			wrote_q <= wrote_d;
		end
	end

	chk_after_writes: assert property ( // RULE11
		wrote_q && rd_rc |=> o_cfg_rdata[31:8] == `GFS_CLASS_RESET
	) else $error("Class code changed after a write.");

	cov_read_status: cover property (rd_sts ##1 o_cfg_ack);

	cov_read_revcls: cover property (rd_rc ##1 o_cfg_ack);

	cov_write_then_read: cover property (wr_any ##1 rd_sts);

	cov_back_to_back: cover property (rd_sts ##1 rd_rc ##1 o_cfg_ack);

	cov_read_and_write: cover property (i_cfg_rd && i_cfg_wr ##1 o_cfg_ack);

endmodule

// [rtl/gfs_params.svh]
// Offsets, field positions, reset values and timing for the function block.
`ifndef GFS_PARAMS_SVH
`define GFS_PARAMS_SVH

// Configuration byte offsets of the registers in this block, and of the capability pointer, which this block does not decode.
`define GFS_OFS_STATUS          8'h06
`define GFS_OFS_REVISION        8'h08
`define GFS_OFS_CLASS           8'h09
`define GFS_OFS_CAP_POINTER     8'h34

// Dword indices that hold those registers.
`define GFS_DW_STATUS           6'h01
`define GFS_DW_REVCLS           6'h02

// Bit position of each register inside its dword.
`define GFS_STATUS_LSB          5'h10
`define GFS_REVISION_LSB        5'h00
`define GFS_CLASS_LSB           5'h08

// Status register reset value and field positions.
`define GFS_STATUS_RESET        16'h0090
`define GFS_BIT_PARITY_FAULT    4'hf
`define GFS_BIT_SYSERR          4'he
`define GFS_BIT_INIT_ABORT      4'hd
`define GFS_BIT_COMP_ABORT      4'hc
`define GFS_BIT_SENT_ABORT      4'hb
`define GFS_BIT_TIMING_HI       4'ha
`define GFS_BIT_TIMING_LO       4'h9
`define GFS_SELECT_TIMING       2'h0
`define GFS_BIT_INIT_PARITY     4'h8
`define GFS_BIT_BACK_TO_BACK    4'h7
`define GFS_BIT_USER_FORMAT     4'h6
`define GFS_BIT_FAST_BUS        4'h5
`define GFS_BIT_CAPS_PRESENT    4'h4
`define GFS_BIT_INTR_STATUS     4'h3
`define GFS_BIT_RSVD_HI         4'h2

// Class code reset value and its three fields.
`define GFS_CLASS_RESET         24'h038000
`define GFS_BASE_CLASS          8'h03
`define GFS_SUB_CLASS           8'h80
`define GFS_PROG_IFACE          8'h00

// Cycles from a taken request to its answer.
`define GFS_ANSWER_CYCLES       2'h1

`endif

// [rtl/gfs_pkg.sv]
// Types shared by the function configuration block.
package gfs_pkg;

	typedef logic [15:0] gfs_status_t;
	typedef logic [23:0] gfs_class_t;
	typedef logic [31:0] gfs_dword_t;

	typedef enum logic [1:0] {
		GFS_REG_NONE,
		GFS_REG_STATUS,
		GFS_REG_REVCLS
	} gfs_region_t;

endpackage

// [rtl/gfs_dword_mux.sv]
// Places the block's registers into the dword that a read selects.
`timescale 1ns/1ps
`include "gfs_params.svh"

module gfs_dword_mux
	import gfs_pkg::*;
(
	input  wire gfs_region_t i_region,
	input  wire gfs_status_t i_status,
	input  wire logic [7:0]  i_revision,
	input  wire gfs_class_t  i_class,
	output gfs_dword_t       o_dword
);

	always_comb begin
		o_dword = '0;
		unique case (i_region)
			GFS_REG_STATUS: begin
				o_dword[`GFS_STATUS_LSB +: 16] = i_status;
			end
			GFS_REG_REVCLS: begin
				o_dword[`GFS_REVISION_LSB +: 8] = i_revision;
				o_dword[`GFS_CLASS_LSB +: 24]   = i_class;
			end
			GFS_REG_NONE: begin
				o_dword = '0;
			end
		endcase
	end

endmodule

// [verification/gfs_host_model.sv]
// Host side model that issues configuration reads and writes.
`timescale 1ns/1ps

module gfs_host_model (
	input  wire logic        i_mclk,
	input  wire logic        i_ack,
	input  wire logic        i_hit,
	input  wire logic [31:0] i_rdata,
	output logic             o_rd,
	output logic             o_wr,
	output logic [7:0]       o_addr,
	output logic [3:0]       o_be,
	output logic [31:0]      o_wdata
);
	initial begin
		o_rd = 1'b0;
		o_wr = 1'b0;
		o_addr = 8'h00;
		o_be = 4'h0;
		o_wdata = 32'h0000_0000;
	end

	// A call starts just after an edge and returns just after the answer.
	task automatic access(input logic rd, input logic wr,
		input logic [7:0] addr, input logic [31:0] wdata,
		output logic [33:0] resp);
		o_rd = rd;
		o_wr = wr;
		o_addr = addr;
		o_be = 4'hf;
		o_wdata = wdata;
		@(posedge i_mclk);
		#2;
		resp = {i_ack, i_hit, i_rdata};
	endtask

	// Read and write requests drop; address, enables and data show the inverse of their last value.
	task automatic idle_bus();
		o_rd = 1'b0;
		o_wr = 1'b0;
		o_addr = ~o_addr;
		o_be = ~o_be;
		o_wdata = ~o_wdata;
	endtask
endmodule

// [verification/tb_gfs_cfg_block.sv]
// Self-checking bench for the function configuration block.
`timescale 1ns/1ps

module tb_gfs_cfg_block;
	import gfs_pkg::*;

	logic        i_mclk = 1'b0;
	logic        i_srst;
	logic        i_cfg_rd;
	logic        i_cfg_wr;
	logic [7:0]  i_cfg_addr;
	logic [3:0]  i_cfg_be;
	logic [31:0] i_cfg_wdata;
	logic [7:0]  i_fn0_revision;
	logic        o_cfg_ack;
	logic        o_cfg_hit;
	logic [31:0] o_cfg_rdata;
	logic [33:0] r;
	logic [7:0]  revs [4] = '{8'h00, 8'h5a, 8'ha5, 8'hff};
	logic [7:0]  miss [5] = '{8'h00, 8'h0c, 8'h10, 8'h34, 8'hfc};
	logic [7:0]  wadr [4] = '{8'h04, 8'h06, 8'h08, 8'h09};
	int          mismatches = 0;
	int          checks = 0;
	int          cycles = 0;

	gfs_cfg_block dut (
		.i_mclk         (i_mclk),
		.i_srst         (i_srst),
		.i_cfg_rd       (i_cfg_rd),
		.i_cfg_wr       (i_cfg_wr),
		.i_cfg_addr     (i_cfg_addr),
		.i_cfg_be       (i_cfg_be),
		.i_cfg_wdata    (i_cfg_wdata),
		.i_fn0_revision (i_fn0_revision),
		.o_cfg_ack      (o_cfg_ack),
		.o_cfg_hit      (o_cfg_hit),
		.o_cfg_rdata    (o_cfg_rdata)
	);

	gfs_host_model host (
		.i_mclk  (i_mclk),
		.i_ack   (o_cfg_ack),
		.i_hit   (o_cfg_hit),
		.i_rdata (o_cfg_rdata),
		.o_rd    (i_cfg_rd),
		.o_wr    (i_cfg_wr),
		.o_addr  (i_cfg_addr),
		.o_be    (i_cfg_be),
		.o_wdata (i_cfg_wdata)
	);

	always #12.5 i_mclk = ~i_mclk;

	task automatic check(input logic [33:0] got, input logic [33:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Releases the bus and checks that the answer lines fall back to zero.
	task automatic gap();
		host.idle_bus();
		@(posedge i_mclk);
		#2;
		check({o_cfg_ack, o_cfg_hit, o_cfg_rdata}, 34'h0);
	endtask

	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			complete_run();
		end
	end

	initial begin
		i_srst = 1'b1;
		i_fn0_revision = 8'h00;
		repeat (3) @(posedge i_mclk);
		#2;
		check({o_cfg_ack, o_cfg_hit, o_cfg_rdata}, 34'h0);
		i_srst = 1'b0;
		@(posedge i_mclk);
		#2;
		for (int i = 4; i < 8; i++) begin
			host.access(1'b1, 1'b0, i[7:0], 32'h0, r);
			check(r, {2'b11, 32'h0090_0000});
			check({29'h0, r[31:27]}, 34'h0);
			check({31'h0, r[26:24]}, 34'h0);
			check({29'h0, r[23:19]}, 34'h12);
		end
		gap();
		for (int i = 0; i < 4; i++) begin
			i_fn0_revision = revs[i];
			host.access(1'b1, 1'b0, 8'h08 + i[7:0], 32'h0, r);
			check(r, {2'b11, 24'h038000, revs[i]});
		end
		gap();
		for (int i = 0; i < 5; i++) begin
			host.access(1'b1, 1'b0, miss[i], 32'h0, r);
			check(r, {2'b10, 32'h0});
		end
		i_fn0_revision = 8'h3c;
		for (int i = 0; i < 4; i++) begin
			host.access(1'b0, 1'b1, wadr[i], 32'hffff_ffff, r);
			check(r, {2'b11, 32'h0});
		end
		host.access(1'b0, 1'b1, 8'h20, 32'hffff_ffff, r);
		check(r, {2'b10, 32'h0});
		host.access(1'b1, 1'b1, 8'h06, 32'hffff_ffff, r);
		check(r, {2'b11, 32'h0090_0000});
		host.access(1'b1, 1'b0, 8'h09, 32'h0, r);
		check(r, {2'b11, 24'h038000, 8'h3c});
		gap();
		complete_run();
	end
endmodule
